// *** src/lmx_pkg.sv ***
// Overview of operation
// - core or fpu access to a free page completes in one cycle
// - prefetch to local memory pulls a block in from external memory
// - writeback to local memory pushes a block out to external memory
// - every block transfer moves exactly 32 bytes
// - low five address bits of a block instruction are treated as zero
// - other page runs on; core access to the busy page stalls
// - translated and protected: external address comes from the tlb entry
// - translated: bits 28:10 from tlb, 9:5 from virtual, 4:0 zero
// - block instructions are checked as reads for tlb miss and protection
// - any exception on a block instruction suppresses the transfer
// - untranslated page 0 source uses its register and select bits
// - untranslated page 0 destination uses its register and select bits
// - page 1 uses its own source and destination registers likewise
// - untranslated: bits 28:16 from register, 15:10 by select bits, 9:5 virtual, 4:0 zero
// - user mode access without user allow raises address error
// - mmu checks only when translation and protection are both on
// - two buses on one page are serialized, both complete
// - system bus masters are not served in sleep mode
// - extended mode widens base fields to bits 31:10
// - select patterns are contiguous ones from the top; 1 takes register
package lmx_pkg;
  // register byte offsets
  localparam logic [4:0] LMX_REG_CTRL = 5'h00;
  localparam logic [4:0] LMX_REG_SRC0 = 5'h04;
  localparam logic [4:0] LMX_REG_DST0 = 5'h08;
  localparam logic [4:0] LMX_REG_SRC1 = 5'h0C;
  localparam logic [4:0] LMX_REG_DST1 = 5'h10;
  localparam logic [4:0] LMX_REG_STAT = 5'h14;
  // control fields
  localparam int LMX_CTRL_PROT = 0;
  localparam int LMX_CTRL_UALLOW = 1;
  localparam int LMX_CTRL_EXT = 2;
  localparam logic [2:0] LMX_CTRL_RST = 3'h0;
  // address register fields
  localparam int LMX_BASE_LSB = 10;
  localparam int LMX_SEL_W = 6;
  localparam logic [31:0] LMX_AREG_MASK = 32'hFFFFFC3F;
  localparam logic [31:0] LMX_AREG_RST = 32'h00000000;
  localparam logic [31:0] LMX_NARROW_MASK = 32'h1FFFFFFF;
  // block geometry
  localparam int LMX_BLK_BYTES = 32;
  localparam int LMX_BLK_BEATS = LMX_BLK_BYTES / 4;
  localparam logic [2:0] LMX_LAST_BEAT = 3'h7;
  typedef enum logic {LMX_IDLE, LMX_BURST} lmx_st_t;
endpackage : lmx_pkg

// *** src/lmx_block.sv ***
`timescale 1ns/100ps
module lmx_block import lmx_pkg::*; #(
  parameter int WORDS = 64
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // mode inputs
  input wire logic translation_enable_in,
  input wire logic privileged_mode_flag_in,
  input wire logic sleep_in,
  // register port
  input wire logic [4:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // core and fpu port
  input wire logic core_req_in,
  input wire logic core_we_in,
  input wire logic [31:0] core_addr_in,
  input wire logic [31:0] core_wdata_in,
  input wire logic core_mmu_fault_in,
  output logic core_ack_out,
  output logic core_stall_out,
  output logic [31:0] core_rdata_out,
  output logic core_addr_err_out,
  output logic core_mmu_err_out,
  // system bus slave port
  input wire logic sb_req_in,
  input wire logic sb_we_in,
  input wire logic [31:0] sb_addr_in,
  input wire logic [31:0] sb_wdata_in,
  output logic sb_ack_out,
  output logic [31:0] sb_rdata_out,
  // block instruction port
  input wire logic blk_req_in,
  input wire logic blk_dir_in,
  input wire logic [31:0] blk_vaddr_in,
  input wire logic tlb_hit_in,
  input wire logic tlb_read_ok_in,
  input wire logic [31:0] tlb_paddr_in,
  output logic blk_ack_out,
  output logic blk_addr_err_out,
  output logic blk_tlb_miss_out,
  output logic blk_prot_err_out,
  output logic blk_done_out,
  // external burst master
  input wire logic ext_ack_in,
  input wire logic [31:0] ext_rdata_in,
  output logic ext_req_out,
  output logic ext_we_out,
  output logic ext_last_out,
  output logic [31:0] ext_addr_out,
  output logic [31:0] ext_wdata_out
);
  localparam int IW = $clog2(WORDS);
  localparam int PB = IW + 2;
  localparam int BW = IW - 3;

  typedef struct packed {
    lmx_st_t st;
    logic [2:0] ctrl;
    logic [3:0][31:0] areg;
    logic [1:0][WORDS-1:0][31:0] mem;
    logic dir;
    logic xp;
    logic [BW-1:0] bi;
    logic [2:0] beat;
    logic [31:0] rrd;
    logic cack;
    logic cstall;
    logic [31:0] crd;
    logic caerr;
    logic cmerr;
    logic sack;
    logic [31:0] srd;
    logic back;
    logic baerr;
    logic btlb;
    logic bprot;
    logic bdone;
    logic ereq;
    logic ewe;
    logic elast;
    logic [31:0] eaddr;
    logic [31:0] ewd;
  } lmx_state_t;

  lmx_state_t s_q;
  lmx_state_t s_d;

  logic trans;
  logic busy;
  logic uerr;
  logic cp;
  logic sp;
  logic bp;
  logic cblk;
  logic cserve;
  logic [31:0] sreg;
  logic [21:0] hi;
  logic [31:0] baddr;
  logic [BW-1:0] nbi;

  // mode decode shared by the core and block paths
  assign trans = translation_enable_in & s_q.ctrl[LMX_CTRL_PROT];
  assign busy = (s_q.st == LMX_BURST);
  assign uerr = ~privileged_mode_flag_in & ~s_q.ctrl[LMX_CTRL_UALLOW];
  // sb uses core numbering, so one page bit decodes both
  assign cp = core_addr_in[PB];
  assign sp = sb_addr_in[PB];
  assign bp = blk_vaddr_in[PB];
  assign nbi = blk_vaddr_in[PB-1:5];
  assign cblk = busy & (cp == s_q.xp);

  // external block address; select bits merge register and operand
  always_comb begin
    sreg = s_q.areg[{bp, blk_dir_in}];
    hi = sreg[31:LMX_BASE_LSB];
    for (int i = 0; i < LMX_SEL_W; i++) begin
      hi[i] = sreg[i] ? sreg[LMX_BASE_LSB + i] : blk_vaddr_in[LMX_BASE_LSB + i];
    end
    if (trans) begin
      hi = tlb_paddr_in[31:LMX_BASE_LSB];
    end
    baddr = {hi, blk_vaddr_in[9:5], 5'h00};
    if (!s_q.ctrl[LMX_CTRL_EXT]) begin
      baddr = baddr & LMX_NARROW_MASK;
    end
  end

  // core wins a same-page clash; sb waits a cycle
  assign cserve = core_req_in & ~uerr & ~(trans & core_mmu_fault_in) & ~cblk;

  // next state
  always_comb begin
    s_d = s_q;
    s_d.cack = 1'b0;
    s_d.cstall = 1'b0;
    s_d.caerr = 1'b0;
    s_d.cmerr = 1'b0;
    s_d.sack = 1'b0;
    s_d.back = 1'b0;
    s_d.baerr = 1'b0;
    s_d.btlb = 1'b0;
    s_d.bprot = 1'b0;
    s_d.bdone = 1'b0;
    s_d.rrd = 32'h00000000;
    // register writes steer mode and address generation
    if (reg_wr_in) begin
      case (reg_addr_in)
        LMX_REG_CTRL: s_d.ctrl = reg_wdata_in[2:0];
        LMX_REG_SRC0: s_d.areg[0] = reg_wdata_in & LMX_AREG_MASK;
        LMX_REG_DST0: s_d.areg[1] = reg_wdata_in & LMX_AREG_MASK;
        LMX_REG_SRC1: s_d.areg[2] = reg_wdata_in & LMX_AREG_MASK;
        LMX_REG_DST1: s_d.areg[3] = reg_wdata_in & LMX_AREG_MASK;
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
    // reads answer next cycle; unmapped reads give zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        LMX_REG_CTRL: s_d.rrd = {29'h00000000, s_q.ctrl};
        LMX_REG_SRC0: s_d.rrd = s_q.areg[0];
        LMX_REG_DST0: s_d.rrd = s_q.areg[1];
        LMX_REG_SRC1: s_d.rrd = s_q.areg[2];
        LMX_REG_DST1: s_d.rrd = s_q.areg[3];
        LMX_REG_STAT: s_d.rrd = {29'h00000000, s_q.dir, s_q.xp, busy};
        default: s_d.rrd = 32'h00000000;
      endcase
      if (!s_q.ctrl[LMX_CTRL_EXT] && reg_addr_in != LMX_REG_CTRL) begin
        s_d.rrd = s_d.rrd & LMX_NARROW_MASK;
      end
    end
    // core and fpu access
    if (core_req_in) begin
      if (uerr) begin
        s_d.caerr = 1'b1;
      end else if (trans && core_mmu_fault_in) begin
        s_d.cmerr = 1'b1;
      end else if (cblk) begin
        s_d.cstall = 1'b1;
      end else begin
        s_d.cack = 1'b1;
        if (core_we_in) begin
          s_d.mem[cp][core_addr_in[PB-1:2]] = core_wdata_in;
        end else begin
          s_d.crd = s_q.mem[cp][core_addr_in[PB-1:2]];
        end
      end
    end
    // system bus access: held off in sleep, on busy page, on clash
    // the request is still held in its ack cycle, so that cycle must not serve it again
    if (sb_req_in && !sleep_in && !(busy && sp == s_q.xp)
        && !(cserve && cp == sp) && !s_q.sack) begin
      s_d.sack = 1'b1;
      if (sb_we_in) begin
        s_d.mem[sp][sb_addr_in[PB-1:2]] = sb_wdata_in;
      end else begin
        s_d.srd = s_q.mem[sp][sb_addr_in[PB-1:2]];
      end
    end
    // block transfer engine
    case (s_q.st)
      LMX_IDLE: begin
        if (blk_req_in && !s_q.back) begin // a faulted request still held is not taken twice
          s_d.back = 1'b1;
          if (uerr) begin
            s_d.baerr = 1'b1;
          end else if (trans && !tlb_hit_in) begin
            s_d.btlb = 1'b1;
          end else if (trans && !tlb_read_ok_in) begin
            s_d.bprot = 1'b1;
          end else begin
            s_d.st = LMX_BURST;
            s_d.dir = blk_dir_in;
            s_d.xp = bp;
            s_d.bi = nbi;
            s_d.beat = 3'h0;
            s_d.ereq = 1'b1;
            s_d.ewe = blk_dir_in;
            s_d.elast = 1'b0;
            s_d.eaddr = baddr;
            s_d.ewd = s_q.mem[bp][{nbi, 3'h0}];
          end
        end
      end
      LMX_BURST: begin
        if (ext_ack_in) begin
          if (!s_q.dir) begin
            s_d.mem[s_q.xp][{s_q.bi, s_q.beat}] = ext_rdata_in;
          end
          s_d.beat = s_q.beat + 3'h1;
          s_d.elast = (s_d.beat == LMX_LAST_BEAT);
          s_d.ewd = s_q.mem[s_q.xp][{s_q.bi, s_d.beat}];
          if (s_q.beat == LMX_LAST_BEAT) begin
            s_d.st = LMX_IDLE;
            s_d.ereq = 1'b0;
            s_d.elast = 1'b0;
            s_d.bdone = 1'b1;
          end
        end
      end
      default: s_d.st = LMX_IDLE;
    endcase
  end

  // single state register; storage is left as it is at reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q <= s_d;
      s_q.st <= LMX_IDLE;
      s_q.ctrl <= LMX_CTRL_RST;
      s_q.areg <= {4{LMX_AREG_RST}};
      s_q.dir <= 1'b0;
      s_q.xp <= 1'b0;
      s_q.bi <= '0;
      s_q.beat <= 3'h0;
      s_q.rrd <= 32'h00000000;
      s_q.cack <= 1'b0;
      s_q.cstall <= 1'b0;
      s_q.crd <= 32'h00000000;
      s_q.caerr <= 1'b0;
      s_q.cmerr <= 1'b0;
      s_q.sack <= 1'b0;
      s_q.srd <= 32'h00000000;
      s_q.back <= 1'b0;
      s_q.baerr <= 1'b0;
      s_q.btlb <= 1'b0;
      s_q.bprot <= 1'b0;
      s_q.bdone <= 1'b0;
      s_q.ereq <= 1'b0;
      s_q.ewe <= 1'b0;
      s_q.elast <= 1'b0;
      s_q.eaddr <= 32'h00000000;
      s_q.ewd <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_out = s_q.rrd;
  assign core_ack_out = s_q.cack;
  assign core_stall_out = s_q.cstall;
  assign core_rdata_out = s_q.crd;
  assign core_addr_err_out = s_q.caerr;
  assign core_mmu_err_out = s_q.cmerr;
  assign sb_ack_out = s_q.sack;
  assign sb_rdata_out = s_q.srd;
  assign blk_ack_out = s_q.back;
  assign blk_addr_err_out = s_q.baerr;
  assign blk_tlb_miss_out = s_q.btlb;
  assign blk_prot_err_out = s_q.bprot;
  assign blk_done_out = s_q.bdone;
  assign ext_req_out = s_q.ereq;
  assign ext_we_out = s_q.ewe;
  assign ext_last_out = s_q.elast;
  assign ext_addr_out = s_q.eaddr;
  assign ext_wdata_out = s_q.ewd;

  // helper: beats seen in the current burst
  logic [3:0] acnt_q;
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      acnt_q <= 4'h0;
    end else if (s_d.back) begin
      acnt_q <= 4'h0;
    end else if (busy && ext_ack_in) begin
      acnt_q <= acnt_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_free_core;
    core_req_in && !uerr && !(trans && core_mmu_fault_in) && !cblk;
  endsequence

  sequence s_start;
    s_q.st == LMX_IDLE && blk_req_in && !blk_ack_out && !uerr
      && !(trans && !(tlb_hit_in && tlb_read_ok_in));
  endsequence

  property p_core_one;
    s_free_core |=> core_ack_out && !core_stall_out;
  endproperty
  a_core_one: assert property (p_core_one) else $error("core access not done in one cycle");

  property p_stall;
    core_req_in && !uerr && !(trans && core_mmu_fault_in) && cblk
      |=> core_stall_out && !core_ack_out;
  endproperty
  a_stall: assert property (p_stall) else $error("busy page access did not stall");

  property p_len;
    $rose(blk_done_out) |-> acnt_q == 4'h8;
  endproperty
  a_len: assert property (p_len) else $error("block did not move eight beats");

  property p_align;
    ext_req_out |-> ext_addr_out[4:0] == 5'h00;
  endproperty
  a_align: assert property (p_align) else $error("block address not aligned");

  property p_mid;
    s_start |=> ext_req_out && ext_addr_out[9:5] == $past(blk_vaddr_in[9:5]);
  endproperty
  a_mid: assert property (p_mid) else $error("address bits 9:5 wrong");

  property p_tlb;
    s_start and trans |=> ext_addr_out[28:10] == $past(tlb_paddr_in[28:10]);
  endproperty
  a_tlb: assert property (p_tlb) else $error("translated address wrong");

  property p_suppress;
    s_q.st == LMX_IDLE && blk_req_in && !blk_ack_out && !uerr && trans && !tlb_hit_in
      |=> blk_tlb_miss_out && !ext_req_out ##1 !ext_req_out;
  endproperty
  a_suppress: assert property (p_suppress) else $error("faulted block still ran");

  property p_user;
    core_req_in && uerr |=> core_addr_err_out && !core_ack_out;
  endproperty
  a_user: assert property (p_user) else $error("user access not refused");

  property p_sleep;
    sleep_in |=> !sb_ack_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("system bus served in sleep");

  property p_clash;
    s_free_core and (sb_req_in && !sleep_in && cp == sp)
      |=> core_ack_out && !sb_ack_out;
  endproperty
  a_clash: assert property (p_clash) else $error("page clash not serialized");

  property p_release;
    busy && ext_ack_in && s_q.beat == LMX_LAST_BEAT
      |=> blk_done_out && !ext_req_out && !busy;
  endproperty
  a_release: assert property (p_release) else $error("burst not ended after last beat");

  property p_narrow;
    ext_req_out && !s_q.ctrl[LMX_CTRL_EXT] |-> ext_addr_out[31:29] == 3'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow mode address too wide");

endmodule : lmx_block

// *** src/lmx_unused_guard.sv ***
`timescale 1ns/100ps

// *** sim/lmx_ext_mem.sv ***
`timescale 1ns/100ps
// external memory on the far side of the block's burst port
module lmx_ext_mem import lmx_pkg::*; (
  // clock, reset and pacing
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic slow_in,
  // burst bus from the block
  input wire logic ext_req_in,
  input wire logic ext_we_in,
  input wire logic ext_last_in,
  input wire logic [31:0] ext_addr_in,
  input wire logic [31:0] ext_wdata_in,
  output logic ext_ack_out,
  output logic [31:0] ext_rdata_out,
  // what the last burst carried
  output logic [3:0] beats_out,
  output logic last_bad_out,
  output logic [31:0] words_out [LMX_BLK_BEATS]
);
  logic [3:0] nxt;
  logic ack_d;
  // beat count including the ack now on the bus
  assign nxt = beats_out + {3'h0, ext_ack_out};
  // slow mode skips every other cycle so the burst stretches out
  assign ack_d = ext_req_in && nxt < 4'h8 && !(slow_in && ext_ack_out);
  // data lines are never left showing the last beat, so a stale sample shows up
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ext_ack_out <= '0;
      ext_rdata_out <= '0;
      beats_out <= '0;
      last_bad_out <= '0;
    end else begin
      ext_ack_out <= ack_d;
      beats_out <= (ext_req_in || ext_ack_out) ? nxt : 4'h0;
      ext_rdata_out <= ack_d ? 32'h5A000000 ^ (ext_addr_in + {26'h0, nxt, 2'h0}) : ~ext_rdata_out;
      if (ext_ack_out && ext_last_in != (beats_out == 4'h7)) last_bad_out <= '1;
      if (ext_ack_out && ext_we_in) words_out[beats_out[2:0]] <= ext_wdata_in;
    end
  end
endmodule : lmx_ext_mem

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import lmx_pkg::*;
  // design inputs, quiet at time zero
  logic clk_in = '0, rstn_in = '0, translation_enable_in = '0, privileged_mode_flag_in = '1;
  logic sleep_in = '0, reg_wr_in = '0, reg_rd_in = '0, core_req_in = '0, core_we_in = '0;
  logic core_mmu_fault_in = '0, sb_req_in = '0, sb_we_in = '0, blk_req_in = '0, blk_dir_in = '0;
  logic tlb_hit_in = '0, tlb_read_ok_in = '0, ext_ack_in, slow = '0, last_bad;
  logic [4:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, core_addr_in = '0, core_wdata_in = '0, sb_addr_in = '0;
  logic [31:0] sb_wdata_in = '0, blk_vaddr_in = '0, tlb_paddr_in = '0, ext_rdata_in;
  // design outputs
  logic [31:0] reg_rdata_out, core_rdata_out, sb_rdata_out, ext_addr_out, ext_wdata_out;
  logic core_ack_out, core_stall_out, core_addr_err_out, core_mmu_err_out, sb_ack_out;
  logic blk_ack_out, blk_addr_err_out, blk_tlb_miss_out, blk_prot_err_out, blk_done_out;
  logic ext_req_out, ext_we_out, ext_last_out;
  logic [3:0] beats;
  logic [31:0] words [LMX_BLK_BEATS];
  logic [31:0] mem [2][8];
  logic [5:0] pats [7] = '{6'h3F, 6'h3E, 6'h3C, 6'h38, 6'h30, 6'h20, 6'h00};
  int n_errors = 0, tests_run = 0, cyc = 0;

  lmx_block #(.WORDS(64)) DUT (.*);
  lmx_ext_mem PARTNER (.clk_in, .rstn_in, .slow_in(slow), .ext_req_in(ext_req_out),
    .ext_we_in(ext_we_out), .ext_last_in(ext_last_out), .ext_addr_in(ext_addr_out),
    .ext_wdata_in(ext_wdata_out), .ext_ack_out(ext_ack_in), .ext_rdata_out(ext_rdata_in),
    .beats_out(beats), .last_bad_out(last_bad), .words_out(words));

  always #10 clk_in = ~clk_in;
  // watchdog, far above the roughly three hundred cycles the run needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      chk("timeout", 32'h0, 32'h1);
      report_and_stop();
    end
  end

  task automatic chk(input string s, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic report_and_stop;
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // register access: write d, or read and expect d in the following cycle
  task automatic rg(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= w;
    reg_rd_in <= !w;
    @(posedge clk_in);
    reg_wr_in <= '0;
    reg_rd_in <= '0;
    #1;
    if (!w) chk("reg_rdata", d, reg_rdata_out);
  endtask : rg

  // one core access; e is {mmu, addr error, stall, ack}
  task automatic cr(input logic we, input logic [31:0] a, d, input logic [3:0] e);
    @(posedge clk_in);
    core_req_in <= '1;
    core_we_in <= we;
    core_addr_in <= a;
    core_wdata_in <= d;
    @(posedge clk_in);
    core_req_in <= '0;
    #1;
    chk("core_resp", {28'h0, e},
      {28'h0, core_mmu_err_out, core_addr_err_out, core_stall_out, core_ack_out});
    if (!we && e == 4'h1) chk("core_rdata", d, core_rdata_out);
  endtask : cr

  // block instruction held until taken; e is {addr error, tlb miss, protection}
  task automatic bk(input logic dir, input logic [31:0] va, input logic [2:0] e,
                    input logic [31:0] x);
    @(posedge clk_in);
    blk_req_in <= '1;
    blk_dir_in <= dir;
    blk_vaddr_in <= va;
    @(posedge clk_in);
    for (int i = 0; i < 50 && blk_ack_out !== 1'h1; i++) @(posedge clk_in);
    blk_req_in <= '0;
    chk("blk_ack", 32'h1, {31'h0, blk_ack_out});
    chk("blk_err", {29'h0, e}, {29'h0, blk_addr_err_out, blk_tlb_miss_out, blk_prot_err_out});
    chk("ext_req", {31'h0, e == 3'h0}, {31'h0, ext_req_out});
    if (e == 3'h0) chk("ext_addr", x, ext_addr_out);
    if (e == 3'h0) chk("ext_we", {31'h0, dir}, {31'h0, ext_we_out});
  endtask : bk

  // wait for the end of a burst and check its length and last beat
  task automatic dn;
    for (int k = 0; k < 60 && blk_done_out !== 1'h1; k++) @(posedge clk_in);
    chk("blk_done", 32'h1, {31'h0, blk_done_out});
    chk("beats", 32'h8, {28'h0, beats});
    chk("last_beat", 32'h0, {31'h0, last_bad});
  endtask : dn

  task automatic sb(input logic [31:0] a, e, output int n);
    @(posedge clk_in);
    sb_req_in <= '1;
    sb_addr_in <= a;
    @(posedge clk_in);
    for (n = 0; n < 30 && sb_ack_out !== 1'h1; n++) @(posedge clk_in);
    sb_req_in <= '0;
    chk("sb_ack", 32'h1, {31'h0, sb_ack_out});
    chk("sb_rdata", e, sb_rdata_out);
  endtask : sb

  // expected untranslated address: select bit 1 takes the register bit
  function automatic logic [31:0] ua(input logic [31:0] r, va);
    logic [31:0] m;
    m = {16'hFFFF, r[5:0], 10'h0};
    return ((r & m) | (va & ~m & 32'h0000FC00) | (va & 32'h000003E0)) & 32'h1FFFFFFF;
  endfunction : ua

  initial begin
    logic pg, dr;
    logic [31:0] va, ad, x;
    int n;
    repeat (4) @(posedge clk_in);
    rstn_in <= '1;
    for (int a = 0; a < 7; a++) rg(0, 5'(a * 4), 32'h0);
    rg(1, LMX_REG_STAT, 32'hFFFFFFFF);
    rg(0, LMX_REG_STAT, 32'h0);
    rg(1, LMX_REG_SRC0, 32'hFFFFFFFF);
    rg(0, LMX_REG_SRC0, 32'h1FFFFC3F);
    rg(1, LMX_REG_CTRL, 32'h4);
    rg(0, LMX_REG_SRC0, 32'hFFFFFC3F);
    rg(1, LMX_REG_CTRL, 32'h0);
    // preload block 3 of both pages through the core port
    for (int w = 0; w < 16; w++) begin
      mem[w / 8][w % 8] = 32'hD0000000 | w;
      cr(1, 32'h60 | ((w / 8) << 8) | ((w % 8) << 2), mem[w / 8][w % 8], 4'h1);
    end
    // every select pattern once, cycling through both pages and both directions
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_in);
      pg = i[1];
      dr = i[0];
      slow <= i[0];
      va = 32'h0000FC7F | {23'h0, pg, 8'h00};
      ad = 32'h0AB40000 | (i << 16) | {26'h0, pats[i]};
      rg(1, 5'h04 + {2'h0, dr, 2'h0} + {1'h0, pg, 3'h0}, ad);
      x = ua(ad, va);
      bk(dr, va, 3'h0, x);
      cr(0, {23'h0, pg, 8'h60}, 32'h0, 4'h2);
      cr(0, {23'h0, !pg, 8'h60}, mem[!pg][0], 4'h1);
      dn();
      for (int w = 0; w < 8; w++) begin
        if (dr) chk("wb_data", mem[pg][w], words[w]);
        else begin
          mem[pg][w] = 32'h5A000000 ^ (x + w * 4);
          cr(0, 32'h60 | {23'h0, pg, 8'h00} | (w << 2), mem[pg][w], 4'h1);
        end
      end
    end
    @(posedge clk_in);
    slow <= '0;
    privileged_mode_flag_in <= '0;
    cr(0, 32'h60, mem[0][0], 4'h4);
    bk(0, 32'h60, 3'h4, 32'h0);
    rg(1, LMX_REG_CTRL, 32'h2);
    cr(0, 32'h60, mem[0][0], 4'h1);
    @(posedge clk_in);
    translation_enable_in <= '1;
    core_mmu_fault_in <= '1;
    cr(0, 32'h60, mem[0][0], 4'h1);
    rg(1, LMX_REG_CTRL, 32'h3);
    cr(0, 32'h60, mem[0][0], 4'h8);
    @(posedge clk_in);
    core_mmu_fault_in <= '0;
    privileged_mode_flag_in <= '1;
    bk(0, 32'h0000FC7F, 3'h2, 32'h0);
    tlb_hit_in <= '1;
    bk(1, 32'h0000FC7F, 3'h1, 32'h0);
    tlb_read_ok_in <= '1;
    tlb_paddr_in <= 32'h012347FF;
    bk(1, 32'h0000FC7F, 3'h0, 32'h01234460);
    dn();
    // the system bus master waits out sleep, then is served
    sleep_in <= '1;
    fork
      sb(32'h64, mem[0][1], n);
      begin
        repeat (12) @(posedge clk_in);
        sleep_in <= '0;
      end
    join
    chk("sb_sleep_wait", 32'h1, {31'h0, n >= 10});
    // core and system bus on one page in the same cycle
    fork
      cr(1, 32'h64, 32'hBEEF0001, 4'h1);
      sb(32'h64, 32'hBEEF0001, n);
    join
    cr(0, 32'h64, 32'hBEEF0001, 4'h1);
    report_and_stop();
  end
endmodule : tb_top
